//--- logic/sosc_switch.sv
// serial octal low side switch control: link shifter plus output latch
`timescale 1ns/1ps
`default_nettype none
`include "sosc_cfg.svh"
module sosc_switch (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic shiftClk,
  input wire logic selN,
  input wire logic serIn,
  output logic serOut,
  output logic serOutOeN,
  input wire logic resetN,
  input wire logic [7:0] drainHigh,
  input wire logic [7:0] channelFault,
  input wire logic shortLatchInhibit,
  output logic [7:0] switchOn,
  output logic [7:0] switchLatchedOff
);
  import sosc_pkg::*;

  // ----------------------------------------
  // link domain: shift register on shiftClk
  // ----------------------------------------
  // reset pin is asynchronous to both clocks; async clear on the link side, synchronised on the ref side
  logic linkRst;
  assign linkRst = rst || !resetN;
  sosc_word_t shift_r;
  logic [3:0] bitCnt_r;
  logic outBit_r;
  sosc_word_t statusSync;
  // capture status on select fall happens asynchronously, so we preload
  // txWord_r with the last synchronised status at select fall; that status
  // is at most a few ref cycles old when the first edge arrives.
  // ignore the clock while deselected; in selected frame sample on fall
  // no ref clock in this path, so shift rate is bounded only by flop timing R05
  always_ff @(negedge shiftClk or posedge linkRst or posedge selN) begin
    if (linkRst) begin
      shift_r <= `SOSC_SHIFT_RESET; // R12
      bitCnt_r <= '0;
    end else if (selN) begin
      shift_r <= `SOSC_SHIFT_RESET; // R10
      bitCnt_r <= '0;
    end else begin
      // msb first: input enters at lsb, status leaves from msb
      shift_r <= {shift_r[6:0], serIn}; // R04 R11
      if (bitCnt_r != 4'hF) begin
        bitCnt_r <= bitCnt_r + 4'h1;
      end
    end
  end
  // status word to send, loaded at select fall by a select-side flop
  sosc_word_t txWord_r;
  logic [2:0] txIdx_r;
  always_ff @(negedge selN or posedge linkRst) begin
    if (linkRst) begin
      txWord_r <= '0;
    end else begin
      txWord_r <= statusSync; // R09 R03
    end
  end
  // status bits on the serial output change on rising shift clock
  always_ff @(posedge shiftClk or posedge selN) begin
    if (selN) begin
      txIdx_r <= 3'h0;
    end else begin
      txIdx_r <= txIdx_r + 3'h1;
    end
  end
  // daisy chain: after eight status bits, pass along the received bits
  always_comb begin
    outBit_r = txWord_r[3'h7 - txIdx_r]; // R11 R03
  end
  logic chainMode_r;
  always_ff @(posedge shiftClk or posedge selN) begin
    if (selN) begin
      chainMode_r <= 1'b0;
    end else if (txIdx_r == 3'h7) begin
      chainMode_r <= 1'b1;
    end
  end
  assign serOut = chainMode_r ? shift_r[7] : outBit_r; // R06
  assign serOutOeN = selN; // R10 R07

  // ----------------------------------------
  // crossing: word captured on select rise
  // ----------------------------------------
  // select rise raises a toggle with the word held stable behind it
  sosc_word_t cmdHold_r;
  logic cmdTgl_r;
  always_ff @(posedge selN or posedge linkRst) begin
    if (linkRst) begin
      cmdHold_r <= `SOSC_OUT_RESET;
      cmdTgl_r <= 1'b0;
    end else if (bitCnt_r >= 4'h8) begin
      // short frames are dropped so outputs keep state
      cmdHold_r <= shift_r; // R09 R13 R01
      cmdTgl_r <= ~cmdTgl_r;
    end
  end
  // ----------------------------------------
  // ref domain
  // ----------------------------------------
  logic resetNSync;
  logic tglSync;
  logic tglSeen_r;
  logic [7:0] drainSync;
  sosc_sync #(.WIDTH(1)) uSyncRst (.clk(ref_clk), .rst(rst), .din(resetN), .dout(resetNSync));
  sosc_sync #(.WIDTH(1)) uSyncTgl (.clk(ref_clk), .rst(rst), .din(cmdTgl_r), .dout(tglSync));
  sosc_sync #(.WIDTH(8)) uSyncDrn (.clk(ref_clk), .rst(rst), .din(drainHigh), .dout(drainSync));
  logic newCmd;
  assign newCmd = tglSync ^ tglSeen_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tglSeen_r <= 1'b0;
    end else begin
      tglSeen_r <= tglSync;
    end
  end
  // command words pass a small fifo before being applied
  logic fifoInReady;
  logic fifoOutValid;
  sosc_word_t fifoOut;
  logic fifoOutReady;
  sosc_fifo #(.WIDTH(`SOSC_WORD_BITS), .DEPTH(`SOSC_FIFO_DEPTH)) uFifo (
    .clk(ref_clk),
    .rst(rst || !resetNSync),
    .inValid(newCmd),
    .inReady(fifoInReady),
    .inData(cmdHold_r),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut)
  );
  // apply one word per cycle; drain stalls never, so fifo never holds more than one word
  assign fifoOutReady = 1'b1;
  sosc_word_t cmd_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_r <= `SOSC_OUT_RESET; // R12
    end else if (!resetNSync) begin
      cmd_r <= `SOSC_OUT_RESET; // R12
    end else if (fifoOutValid) begin
      cmd_r <= fifoOut; // R13
    end
  end
  // per channel fault latch, independent of the others
  sosc_word_t faultSync;
  sosc_sync #(.WIDTH(8)) uSyncFlt (.clk(ref_clk), .rst(rst), .din(channelFault), .dout(faultSync));
  logic inhibitSync;
  sosc_sync #(.WIDTH(1)) uSyncInh (.clk(ref_clk), .rst(rst), .din(shortLatchInhibit),
    .dout(inhibitSync));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      switchLatchedOff <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (fifoOutValid || !resetNSync) begin
          switchLatchedOff[i] <= 1'b0; // new command unlatches
        end else if (faultSync[i] && !inhibitSync && switchOn[i]) begin
          switchLatchedOff[i] <= 1'b1; // R08
        end
      end
    end
  end
  // inverted polarity: 0 means conducting
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      switchOn <= '0;
    end else begin
      switchOn <= ~cmd_r & ~switchLatchedOff; // R02 R08
    end
  end
  // status reported high for an off or faulted-open drain
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      statusSync <= '1;
    end else begin
      statusSync <= drainSync; // R03
    end
  end

  a_reset_all_off: assert property (@(posedge ref_clk) disable iff (rst)
    !resetNSync ##1 !resetNSync |=> switchOn == 8'h00) else $error("outputs on in reset"); // R12
  a_polarity_apply: assert property (@(posedge ref_clk) disable iff (rst)
    resetNSync && fifoOutValid && switchLatchedOff == 8'h00 ##1 resetNSync
    |=> switchOn == (~$past(fifoOut, 2) & ~$past(switchLatchedOff)))
    else $error("polarity wrong"); // R02
  a_hold_no_cmd: assert property (@(posedge ref_clk) disable iff (rst)
    resetNSync && !fifoOutValid |=> cmd_r == $past(cmd_r)) else $error("cmd changed"); // R13
  a_fault_isolated: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(switchLatchedOff[0]) |-> $past(faultSync[0])) else $error("latch without fault"); // R08
  a_hiz_deselect: assert property (@(posedge ref_clk) disable iff (rst)
    selN |-> serOutOeN) else $error("driving while deselected"); // R10
  a_fifo_ready: assert property (@(posedge ref_clk) disable iff (rst)
    newCmd |-> fifoInReady) else $error("command lost"); // R09
  a_inhibit_hold: assert property (@(posedge ref_clk) disable iff (rst)
    inhibitSync && !fifoOutValid && resetNSync |=> switchLatchedOff == $past(switchLatchedOff))
    else $error("latched despite inhibit"); // R08
  a_status_follow: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> statusSync == $past(drainSync)) else $error("status stale"); // R03
endmodule : sosc_switch
`default_nettype wire

//--- logic/sosc_cfg.svh
// constants for the serial octal switch control block
// Functional notes
// [R01] eight switch outputs are driven from one 8-bit serial command word, one bit per output.
// [R02] a command bit of 0 turns its output on and a bit of 1 turns it off.
// [R03] while commands are shifted in, the drain status of every output is shifted back out.
// [R04] each shift clock cycle moves one bit in and one bit out at the same time.
// [R05] the serial link works with shift clocks up to and beyond 3.0 MHz.
// [R06] devices chain through their serial output into the next serial input under one select.
// [R07] devices sharing clock and data answer only while their own select is low.
// [R08] each channel has its own fault control and a fault on one leaves the others alone.
// [R09] select rising applies the command word; select falling loads drain status to the shifter.
// [R10] while select is high clock and input are ignored and the serial output floats.
// [R11] words shift most significant bit first, first bit for output 7, status in the same order.
// [R12] the active low reset clears the shift register and turns all eight outputs off.
// [R13] outputs keep their state until a full transfer ends with select rising, or a reset.
`ifndef SOSC_CFG_SVH
`define SOSC_CFG_SVH
`define SOSC_WORD_BITS 8
`define SOSC_OUT_RESET 8'hFF
`define SOSC_SHIFT_RESET 8'h00
`define SOSC_FIFO_DEPTH 4
`define SOSC_SCLK_MAX_KHZ 3000
`endif

//--- logic/sosc_pkg.sv
// types for the serial octal switch control block
package sosc_pkg;
  typedef logic [7:0] sosc_word_t;
  typedef enum logic [1:0] {SOSC_IDLE, SOSC_APPLY} sosc_state_e;
endpackage : sosc_pkg

//--- logic/sosc_fifo.sv
// small valid/ready word fifo
`timescale 1ns/1ps
`default_nettype none
module sosc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r;
  logic [AW:0] rdPtr_r;
  logic [AW:0] count;
  // ----------------------------------------
  // flags
  // ----------------------------------------
  assign count = wrPtr_r - rdPtr_r;
  assign inReady = (count != DEPTH[AW:0]);
  assign outValid = (count != '0);
  assign outData = mem[rdPtr_r[AW-1:0]];
  // write side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
    end else if (inValid && inReady) begin
      wrPtr_r <= wrPtr_r + 1'b1;
    end
  end
  // storage has no reset, data only
  always_ff @(posedge clk) begin
    if (inValid && inReady) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end
  // read side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdPtr_r <= '0;
    end else if (outValid && outReady) begin
      rdPtr_r <= rdPtr_r + 1'b1;
    end
  end
  a_fifo_no_over: assert property (@(posedge clk) disable iff (rst)
    count <= DEPTH[AW:0]) else $error("fifo overfilled");
endmodule : sosc_fifo
`default_nettype wire

//--- logic/sosc_sync.sv
// two flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sosc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;
  // first stage read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule : sosc_sync
`default_nettype wire

//--- bench/sosc_host.sv
// host model: serial bus master driving the switch block's link
`timescale 1ns/1ps
`default_nettype none
module sosc_host #(
  parameter int HALF_NS = 6
) (
  output logic shiftClk,
  output logic selN,
  output logic serIn,
  input wire logic soWire
);
  // idle: clock parked low, select high
  initial begin
    shiftClk = 1'b0;
    selN = 1'b1;
    serIn = 1'b0;
  end
  // one frame, msb first, clock low at both select edges
  task automatic xfer(input logic [15:0] tx, input int nBits, output logic [15:0] rx);
    rx = '0;
    #(HALF_NS) selN = 1'b0;
    #50;
    for (int i = nBits - 1; i >= 0; i--) begin
      // move data a little after the falling edge so the device keeps its hold time
      #(HALF_NS / 2) serIn = tx[i];
      #(HALF_NS - HALF_NS / 2);
      rx = {rx[14:0], soWire};
      shiftClk = 1'b1;
      #(HALF_NS) shiftClk = 1'b0;
    end
    #50 selN = 1'b1;
    serIn = ~serIn; // released line must not keep its value
  endtask : xfer
  // stray clocking with select high, only for the ignore test
  task automatic idleClk();
    repeat (4) begin
      serIn = ~serIn;
      #(HALF_NS) shiftClk = 1'b1;
      #(HALF_NS) shiftClk = 1'b0;
    end
  endtask : idleClk
endmodule : sosc_host
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the serial switch block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk, rst, resetN, shortLatchInhibit;
  logic [7:0] drainHigh, channelFault, switchOn, switchLatchedOff, keep;
  logic shiftClk, selN, serIn, serOut, serOutOeN, soHeld;
  wire logic soWire;
  logic [15:0] rx;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] rowCmd [4] = '{8'h00, 8'hFF, 8'hA5, 8'h3C};
  logic [7:0] rowDrain [4] = '{8'hFF, 8'h00, 8'h5A, 8'hC3};
  // floating output shows the inverse of its last level
  always @(posedge serOutOeN) soHeld = serOut;
  assign soWire = serOutOeN ? ~soHeld : serOut;
  sosc_switch u_dut (.ref_clk(ref_clk), .rst(rst), .shiftClk(shiftClk), .selN(selN),
    .serIn(serIn), .serOut(serOut), .serOutOeN(serOutOeN), .resetN(resetN),
    .drainHigh(drainHigh), .channelFault(channelFault), .shortLatchInhibit(shortLatchInhibit),
    .switchOn(switchOn), .switchLatchedOff(switchLatchedOff));
  sosc_host u_host (.shiftClk(shiftClk), .selN(selN), .serIn(serIn), .soWire(soWire));
  // 200 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // hang guard, well above the some five hundred cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic waitClk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : waitClk
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    resetN = 1'b0;
    drainHigh = 8'hFF;
    channelFault = 8'h00;
    shortLatchInhibit = 1'b1;
    waitClk(16);
    rst = 1'b0;
    resetN = 1'b1;
    waitClk(8);
    chk("switchOn after reset", 8'h00, switchOn);
    // ordinary frames: command and drain level in, status and outputs out
    foreach (rowCmd[i]) begin
      drainHigh = rowDrain[i];
      waitClk(8);
      u_host.xfer({8'h00, rowCmd[i]}, 8, rx);
      waitClk(20);
      chk("status word", rowDrain[i], rx[7:0]);
      chk("switchOn", ~rowCmd[i], switchOn);
      $display("row %0d done", i);
    end
    // chained frame: first byte passes through, last byte decides
    u_host.xfer(16'hC35A, 16, rx);
    waitClk(20);
    chk("chain status", rowDrain[3], rx[15:8]);
    chk("chain pass", 8'hC3, rx[7:0]);
    chk("chain switchOn", 8'hA5, switchOn);
    $display("chain test done");
    // short frame and stray clocks must leave outputs alone
    keep = switchOn;
    u_host.xfer(16'h000F, 4, rx);
    waitClk(20);
    chk("short frame", keep, switchOn);
    u_host.idleClk();
    waitClk(20);
    chk("deselected clocks", keep, switchOn);
    chk("output enable", 8'h01, {7'h00, serOutOeN});
    $display("ignore tests done");
    // fault on channel 3 only
    u_host.xfer(16'h0000, 8, rx);
    shortLatchInhibit = 1'b0;
    channelFault = 8'h08;
    waitClk(30);
    chk("other channels", 8'hF7, switchOn & 8'hF7);
    chk("fault latch", 8'h08, switchLatchedOff & 8'h08);
    channelFault = 8'h00;
    $display("fault test done");
    // device reset in mid run
    resetN = 1'b0;
    waitClk(4);
    chk("switchOn in reset", 8'h00, switchOn);
    resetN = 1'b1;
    $display("reset test done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
